// ===== bcs_pkg.sv
// Constants, register map and state types of the charge sequencer
package bcs_pkg;
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned OSC_HZ        = 200;
    localparam int unsigned MAINS_HZ      = 50;
    localparam int unsigned OSC_DIV       = CLK_HZ / OSC_HZ;
    localparam logic [2:0]  OSC_STEP      = 3'h1;
    localparam logic [2:0]  MAINS_STEP    = 3'(OSC_HZ / MAINS_HZ);
    localparam logic [2:0]  EXT_STEP      = 3'h1;
    localparam int unsigned WAIT_S        = 2;
    localparam logic [8:0]  WAIT_UNITS    = 9'(WAIT_S * OSC_HZ);
    localparam int unsigned SHORT_MIN     = 30;
    localparam int unsigned MEDIUM_MIN    = 60;
    localparam int unsigned LONG_MIN      = 720;
    localparam int unsigned SHORT_UNITS   = SHORT_MIN * 60 * OSC_HZ;
    localparam int unsigned MEDIUM_UNITS  = MEDIUM_MIN * 60 * OSC_HZ;
    localparam int unsigned LONG_UNITS    = LONG_MIN * 60 * OSC_HZ;
    localparam logic [6:0]  FLASH_PERIOD  = 7'h64;
    localparam logic [6:0]  FLASH_ON      = 7'h32;
    localparam logic [6:0]  TRICKLE_ON    = 7'h05;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_CLR  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_EN   = 8'h10;
    // Control fields
    localparam int unsigned CTRL_TSEL_LO  = 0;
    localparam int unsigned CTRL_TSEL_HI  = 1;
    localparam int unsigned CTRL_FAIL     = 2;
    localparam int unsigned CTRL_MAINS    = 3;
    localparam int unsigned CTRL_EXT      = 4;
    localparam logic [4:0]  CTRL_RESET    = 5'h00;
    localparam logic [1:0]  TSEL_SHORT    = 2'h0;
    localparam logic [1:0]  TSEL_MEDIUM   = 2'h1;
    // Interrupt bits
    localparam int unsigned IRQ_CONTACT   = 0;
    localparam int unsigned IRQ_DIS_DONE  = 1;
    localparam int unsigned IRQ_CHG_DONE  = 2;
    localparam int unsigned IRQ_VIOL      = 3;
    localparam int unsigned IRQ_FAIL      = 4;
    localparam int unsigned IRQ_W         = 5;
    localparam logic [1:0]  VIOL_LIMIT    = 2'h2;
    typedef enum logic [2:0] {
        ST_NO_BAT, ST_WAIT, ST_DISCHARGE, ST_CHARGE, ST_TRICKLE
    } bcs_state_type;
endpackage : bcs_pkg

// ===== bcs_rst_sync.sv
// Two-stage release of the asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module bcs_rst_sync (
    // Clock and raw reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // Released reset
    output var  logic o_rstn
);
    typedef struct packed {
        logic meta;
        logic hold;
    } bcs_rs_type;
    bcs_rs_type q;
    bcs_rs_type next_q;
    always_comb begin
        next_q.meta = 1'b1;
        next_q.hold = q.meta;
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign o_rstn = q.hold;
endmodule : bcs_rst_sync
`default_nettype wire

// ===== bcs_tick.sv
// Base tick from oscillator divider or mains sync, and timer tick
`timescale 1ns/1ps
`default_nettype none
module bcs_tick #(
    parameter int unsigned OSC_DIV = bcs_pkg::OSC_DIV
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    // Sources and selection
    input  wire logic       i_mains_sel,
    input  wire logic       i_ext_sel,
    input  wire logic       i_mains_sync,
    input  wire logic       i_ext_tclk,
    // Ticks with their weight in oscillator units
    output var  logic [2:0] o_base_step,
    output var  logic [2:0] o_timer_step
);
    typedef struct packed {
        logic [19:0] div;
        logic        mains_d;
        logic        ext_d;
        logic [2:0]  base;
        logic [2:0]  timer;
    } bcs_tick_type;
    bcs_tick_type q;
    bcs_tick_type next_q;
    logic osc_tick;
    logic mains_edge;
    always_comb begin
        next_q = q;
        osc_tick = (q.div == 20'(OSC_DIV - 1));
        mains_edge = i_mains_sync && !q.mains_d;
        next_q.div = osc_tick ? 20'h00000 : q.div + 20'h00001;
        next_q.mains_d = i_mains_sync;
        next_q.ext_d = i_ext_tclk;
        if (i_mains_sel) begin
            next_q.base = mains_edge ? bcs_pkg::MAINS_STEP : 3'h0;
        end else begin
            next_q.base = osc_tick ? bcs_pkg::OSC_STEP : 3'h0;
        end
        // External timer clock drives only the period
        if (i_ext_sel) begin
            next_q.timer = (i_ext_tclk && !q.ext_d) ? bcs_pkg::EXT_STEP : 3'h0;
        end else begin
            next_q.timer = next_q.base;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
    assign o_base_step = q.base;
    assign o_timer_step = q.timer;
endmodule : bcs_tick
`default_nettype wire

// ===== bcs_top.sv
// Charge sequencer: state machine, outputs, AHB-Lite registers
// Functional notes
// - No battery after power-up: status steady red.
// - Contact seen: wait two seconds, then pre-discharge with discharge enabled.
// - Pre-discharge shows flashing red.
// - Discharge stop: discharge off, charge on, flashing green.
// - Charge lasts 0.5 h, 1 h or pulsed 12 h, then trickle.
// - Trickle shows steady green.
// - Limit flag active halts charge timer until it clears.
// - Overvoltage or low temperature turns off both enables.
// - Violation counter counts limit events; two trigger failure handling.
// - Failure mode low: cancel after two, trickle, blinking red.
// - Failure mode high: alternate red/green, timer resumes after each violation.
// - Mains select disconnects oscillator; otherwise oscillator clocks timer unless the external timer clock is selected.
// - Contact delay and flash rate come from the 200 Hz base.
// - A 50 Hz mains clock may serve as timer source.
// - External timer clock sets period; control still on base clock.
// - PWM ramp above level masks both enables in every mode.
// - Contact lost: status returns to steady red at once.
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module bcs_top #(
    parameter int unsigned OSC_DIV      = bcs_pkg::OSC_DIV,
    parameter int unsigned SHORT_UNITS  = bcs_pkg::SHORT_UNITS,
    parameter int unsigned MEDIUM_UNITS = bcs_pkg::MEDIUM_UNITS,
    parameter int unsigned LONG_UNITS   = bcs_pkg::LONG_UNITS
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    // Comparator flags and clock sources
    input  wire logic        i_contact,
    input  wire logic        i_discharge_stop,
    input  wire logic        i_overvoltage,
    input  wire logic        i_low_temp,
    input  wire logic        i_pwm_above,
    input  wire logic        i_mains_sync,
    input  wire logic        i_ext_tclk,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Switches, status LED and interrupt
    output var  logic        o_discharge_en,
    output var  logic        o_charge_en,
    output var  logic        o_led_red,
    output var  logic        o_led_green,
    output var  logic        o_irq
);
    typedef struct packed {
        bcs_pkg::bcs_state_type  st;
        logic [8:0]              wait_cnt;
        logic [23:0]             chg_cnt;
        logic [6:0]              flash_cnt;
        logic [1:0]              viol_cnt;
        logic                    limit_d;
        logic                    cancelled;
        logic [4:0]              ctrl;
        logic                    wr_pend;
        logic [7:0]              wr_addr;
        logic [bcs_pkg::IRQ_W-1:0] irq_stat;
        logic [bcs_pkg::IRQ_W-1:0] irq_en;
        logic [31:0]             rdata;
        logic                    ready;
        logic                    dis_en;
        logic                    chg_en;
        logic                    red;
        logic                    green;
        logic                    irq;
    } bcs_top_type;

    bcs_top_type q;
    bcs_top_type next_q;
    logic        rstn;
    logic [2:0]  base_step;
    logic [2:0]  timer_step;

    // Saturating add of a weighted tick
    function automatic logic [23:0] sat_add(input logic [23:0] cnt,
                                            input logic [2:0] step,
                                            input logic [23:0] lim);
        logic [24:0] sum;
        sum = {1'b0, cnt} + {22'h000000, step};
        sat_add = (sum >= {1'b0, lim}) ? lim : sum[23:0];
    endfunction : sat_add

    function automatic logic [23:0] term_count(input logic [1:0] tsel);
        if (tsel == bcs_pkg::TSEL_SHORT) begin
            term_count = 24'(SHORT_UNITS);
        end else if (tsel == bcs_pkg::TSEL_MEDIUM) begin
            term_count = 24'(MEDIUM_UNITS);
        end else begin
            term_count = 24'(LONG_UNITS);
        end
    endfunction : term_count

    bcs_rst_sync u_rst (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .o_rstn    (rstn)
    );

    bcs_tick #(
        .OSC_DIV (OSC_DIV)
    ) u_tick (
        .i_ref_clk    (i_ref_clk),
        .i_rstn       (rstn),
        .i_mains_sel  (q.ctrl[bcs_pkg::CTRL_MAINS]),
        .i_ext_sel    (q.ctrl[bcs_pkg::CTRL_EXT]),
        .i_mains_sync (i_mains_sync),
        .i_ext_tclk   (i_ext_tclk),
        .o_base_step  (base_step),
        .o_timer_step (timer_step)
    );

    logic                    limit;
    logic                    viol;
    logic                    flash;
    logic                    alt_mode;
    logic [23:0]             term;
    logic [6:0]              fsum;
    logic [23:0]             wsum;
    logic                    addr_ok;
    logic [bcs_pkg::IRQ_W-1:0] ev;
    logic [bcs_pkg::IRQ_W-1:0] clr;

    always_comb begin
        next_q = q;
        ev = '0;
        clr = '0;
        limit = i_overvoltage || i_low_temp;
        viol = limit && !q.limit_d;
        flash = (q.flash_cnt < bcs_pkg::FLASH_ON);
        alt_mode = q.ctrl[bcs_pkg::CTRL_FAIL] && (q.viol_cnt == bcs_pkg::VIOL_LIMIT);
        term = term_count(q.ctrl[bcs_pkg::CTRL_TSEL_HI:bcs_pkg::CTRL_TSEL_LO]);
        next_q.limit_d = limit;
        wsum = sat_add({15'h0000, q.wait_cnt}, base_step, {15'h0000, bcs_pkg::WAIT_UNITS});
        // Flash phase on the base tick
        fsum = q.flash_cnt + {4'h0, base_step};
        next_q.flash_cnt = (fsum >= bcs_pkg::FLASH_PERIOD) ? 7'h00 : fsum;

        case (q.st)
            bcs_pkg::ST_NO_BAT: begin
                if (i_contact) begin
                    next_q.st = bcs_pkg::ST_WAIT;
                    next_q.wait_cnt = '0;
                    ev[bcs_pkg::IRQ_CONTACT] = 1'b1;
                end
            end
            bcs_pkg::ST_WAIT: begin
                next_q.wait_cnt = wsum[8:0];
                if (q.wait_cnt == bcs_pkg::WAIT_UNITS) begin
                    next_q.st = bcs_pkg::ST_DISCHARGE;
                end
            end
            bcs_pkg::ST_DISCHARGE: begin
                if (i_discharge_stop) begin
                    next_q.st = bcs_pkg::ST_CHARGE;
                    next_q.chg_cnt = '0;
                    ev[bcs_pkg::IRQ_DIS_DONE] = 1'b1;
                end
            end
            bcs_pkg::ST_CHARGE: begin
                // Timer frozen while a limit is active
                if (!limit) begin
                    // Count timer ticks to terminal count
                    next_q.chg_cnt = sat_add(q.chg_cnt, timer_step, term);
                end
                if (q.chg_cnt == term) begin
                    next_q.st = bcs_pkg::ST_TRICKLE;
                    ev[bcs_pkg::IRQ_CHG_DONE] = 1'b1;
                end
            end
            bcs_pkg::ST_TRICKLE: begin
                next_q.st = bcs_pkg::ST_TRICKLE;
            end
            default: begin
                next_q.st = bcs_pkg::ST_NO_BAT;
            end
        endcase

        if (viol && (q.st != bcs_pkg::ST_NO_BAT) && (q.viol_cnt != bcs_pkg::VIOL_LIMIT)) begin
            next_q.viol_cnt = q.viol_cnt + 2'h1;
            ev[bcs_pkg::IRQ_VIOL] = 1'b1;
            if (q.viol_cnt + 2'h1 == bcs_pkg::VIOL_LIMIT) begin
                ev[bcs_pkg::IRQ_FAIL] = 1'b1;
            end
        end
        // Failure mode low cancels into trickle
        if (!q.ctrl[bcs_pkg::CTRL_FAIL] && (q.viol_cnt == bcs_pkg::VIOL_LIMIT)
            && (q.st != bcs_pkg::ST_NO_BAT) && !q.cancelled) begin
            next_q.st = bcs_pkg::ST_TRICKLE;
            next_q.cancelled = 1'b1;
        end
        if (!i_contact) begin
            next_q.st = bcs_pkg::ST_NO_BAT;
            next_q.viol_cnt = '0;
            next_q.cancelled = 1'b0;
        end

        // Enables and display
        next_q.dis_en = (next_q.st == bcs_pkg::ST_DISCHARGE);
        next_q.chg_en = 1'b0;
        if (next_q.st == bcs_pkg::ST_CHARGE) begin
            next_q.chg_en = (term == 24'(LONG_UNITS)) ? flash : 1'b1;
        end else if (next_q.st == bcs_pkg::ST_TRICKLE) begin
            next_q.chg_en = (q.flash_cnt < bcs_pkg::TRICKLE_ON);
        end
        // PWM ramp above level masks both switches
        if (limit || i_pwm_above) begin
            next_q.dis_en = 1'b0;
            next_q.chg_en = 1'b0;
        end
        case (next_q.st)
            bcs_pkg::ST_NO_BAT: begin
                next_q.red = 1'b1;
                next_q.green = 1'b0;
            end
            bcs_pkg::ST_WAIT: begin
                next_q.red = 1'b1;
                next_q.green = 1'b0;
            end
            bcs_pkg::ST_DISCHARGE: begin
                next_q.red = flash;
                next_q.green = 1'b0;
            end
            bcs_pkg::ST_CHARGE: begin
                next_q.red = 1'b0;
                next_q.green = flash;
            end
            default: begin
                next_q.red = 1'b0;
                next_q.green = 1'b1;
            end
        endcase
        if (next_q.cancelled) begin
            next_q.red = flash;
            next_q.green = 1'b0;
        end else if (alt_mode && (next_q.st != bcs_pkg::ST_NO_BAT)) begin
            next_q.red = flash;
            next_q.green = !flash;
        end

        // AHB-Lite slave, zero wait states
        next_q.ready = 1'b1;
        next_q.wr_pend = 1'b0;
        if (q.wr_pend) begin
            if (q.wr_addr == bcs_pkg::ADDR_CTRL) begin
                next_q.ctrl = hwdata[4:0];
            end else if (q.wr_addr == bcs_pkg::ADDR_IRQ_CLR) begin
                clr = hwdata[bcs_pkg::IRQ_W-1:0];
            end else if (q.wr_addr == bcs_pkg::ADDR_IRQ_EN) begin
                next_q.irq_en = hwdata[bcs_pkg::IRQ_W-1:0];
            end
        end
        addr_ok = hsel && hready && htrans[1];
        if (addr_ok) begin
            next_q.wr_pend = hwrite;
            next_q.wr_addr = haddr[7:0];
            next_q.rdata = 32'h00000000;
            if (!hwrite) begin
                if (haddr[7:0] == bcs_pkg::ADDR_CTRL) begin
                    next_q.rdata = {27'h0000000, q.ctrl};
                end else if (haddr[7:0] == bcs_pkg::ADDR_STATUS) begin
                    next_q.rdata = {24'h000000, q.cancelled, q.viol_cnt, 2'h0, q.st};
                end else if (haddr[7:0] == bcs_pkg::ADDR_IRQ_STAT) begin
                    next_q.rdata = {27'h0000000, q.irq_stat};
                end else if (haddr[7:0] == bcs_pkg::ADDR_IRQ_EN) begin
                    next_q.rdata = {27'h0000000, q.irq_en};
                end
            end
        end
        // Set wins over clear
        next_q.irq_stat = (q.irq_stat & ~clr) | ev;
        next_q.irq = |(next_q.irq_stat & next_q.irq_en);
    end

    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.st <= bcs_pkg::ST_NO_BAT;
            q.ctrl <= bcs_pkg::CTRL_RESET;
            q.red <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign hrdata = q.rdata;
    assign hreadyout = q.ready;
    assign hresp = 1'b0;
    assign o_discharge_en = q.dis_en;
    assign o_charge_en = q.chg_en;
    assign o_led_red = q.red;
    assign o_led_green = q.green;
    assign o_irq = q.irq;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rstn);

    a_limit_off: assert property ((i_overvoltage || i_low_temp) |=> (!o_discharge_en && !o_charge_en))
        else $error("enable active during limit");
    a_pwm_mask: assert property (i_pwm_above |=> (!o_discharge_en && !o_charge_en))
        else $error("enable active with ramp above level");
    a_contact_red: assert property (!i_contact |=> (q.st == bcs_pkg::ST_NO_BAT) && o_led_red && !o_led_green)
        else $error("no steady red after contact loss");
    a_dis_state: assert property (o_discharge_en |-> (q.st == bcs_pkg::ST_DISCHARGE))
        else $error("discharge outside pre-discharge");
    a_dis_entry: assert property ((q.st == bcs_pkg::ST_DISCHARGE) && ($past(q.st) != bcs_pkg::ST_DISCHARGE) |-> ($past(q.st) == bcs_pkg::ST_WAIT) && ($past(q.wait_cnt) == bcs_pkg::WAIT_UNITS))
        else $error("pre-discharge entered early");
    a_timer_hold: assert property ((q.st == bcs_pkg::ST_CHARGE) && (i_overvoltage || i_low_temp) && i_contact |=> $stable(q.chg_cnt))
        else $error("charge timer moved during limit");
    a_trickle_green: assert property ((q.st == bcs_pkg::ST_TRICKLE) && !q.cancelled && !alt_mode |-> o_led_green && !o_led_red)
        else $error("trickle not steady green");
    a_fail_cancel: assert property (!q.ctrl[bcs_pkg::CTRL_FAIL] && (q.viol_cnt == bcs_pkg::VIOL_LIMIT) && i_contact && (q.st != bcs_pkg::ST_NO_BAT) |=> (q.st == bcs_pkg::ST_TRICKLE) && q.cancelled)
        else $error("failure did not cancel charge");
    a_viol_count: assert property ($past(q.viol_cnt) != q.viol_cnt && i_contact |-> q.viol_cnt == $past(q.viol_cnt) + 2'h1)
        else $error("violation counter jumped");
    a_bus_okay: assert property ($past(rstn) |-> hreadyout && !hresp)
        else $error("bus response not OKAY");

    c_full_cycle: cover property ((q.st == bcs_pkg::ST_CHARGE) ##1 (q.st == bcs_pkg::ST_TRICKLE));
    c_cancel: cover property ($rose(q.cancelled));
    c_alt_mode: cover property (alt_mode && o_led_green);
    c_irq: cover property ($rose(o_irq));
endmodule : bcs_top
`default_nettype wire

// ===== bcs_battery_model.sv
// Battery pack model with discharge level and fault flags
`timescale 1ns/1ps
`default_nettype none
module bcs_battery_model (
    // Clock
    input  wire logic i_ref_clk,
    // Operator and fault controls
    input  wire logic i_insert,
    input  wire logic i_hot,
    input  wire logic i_cold,
    // Switch enable from the sequencer
    input  wire logic i_discharge_en,
    // Comparator flags
    output var  logic o_contact,
    output var  logic o_discharge_stop,
    output var  logic o_overvoltage,
    output var  logic o_low_temp
);
    logic [11:0] level;
    // Cell empties only while the discharge switch is on
    always_ff @(posedge i_ref_clk) begin
        if (!i_insert)
            level <= 12'h200;
        else if (i_discharge_en && level != 12'h000)
            level <= level - 12'h001;
    end
    // Flags read low once the pack is out
    assign o_contact        = i_insert;
    assign o_discharge_stop = i_insert && level == 12'h000;
    assign o_overvoltage    = i_insert && i_hot;
    assign o_low_temp       = i_insert && i_cold;
endmodule : bcs_battery_model
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rstn = 0, ins = 0, hot = 0, cold = 0, pwm = 0, mains = 0;
    logic hsel = 0, hwrite = 0, hreadyout, hresp, den, cen, red, grn, irq;
    logic con, dst, ov, lt, ext = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    int miscompares = 0, checks = 0, cyc = 0, nr, ng, nb, el;
    time t0;
    bcs_top #(.OSC_DIV(2), .SHORT_UNITS(200), .MEDIUM_UNITS(400), .LONG_UNITS(600)) bcs_top_inst (
        .i_ref_clk(clk), .i_rstn(rstn), .i_contact(con), .i_discharge_stop(dst),
        .i_overvoltage(ov), .i_low_temp(lt), .i_pwm_above(pwm), .i_mains_sync(mains),
        .i_ext_tclk(ext), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .o_discharge_en(den), .o_charge_en(cen),
        .o_led_red(red), .o_led_green(grn), .o_irq(irq));
    bcs_battery_model bcs_battery_model_inst (.i_ref_clk(clk), .i_insert(ins), .i_hot(hot),
        .i_cold(cold), .i_discharge_en(den), .o_contact(con), .o_discharge_stop(dst),
        .o_overvoltage(ov), .o_low_temp(lt));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : xfer
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 2000 && rd[2:0] !== s; i++) xfer(1'b0, 8'h04, 32'h0);
        chk(32'(rd[2:0]), 32'(s));
    endtask : wait_st
    task automatic observe(input int n);
        {nr, ng, nb} = 96'h0;
        repeat (n) begin
            @(posedge clk);
            nr += int'(red);
            ng += int'(grn);
            nb += int'(red & grn);
        end
    endtask : observe
    task automatic insert(input logic [31:0] ctrl);
        xfer(1'b1, 8'h00, ctrl);
        ins <= 1'b1;
        rd = 32'h0;
        wait_st(3'h3);
    endtask : insert
    task automatic remove();
        ins <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'({red, grn}), 32'h2);
        rdc(8'h04, 32'h0);
        repeat (900) @(posedge clk);
    endtask : remove
    task automatic t_reset();
        chk(32'({red, grn, den, cen}), 32'h8);
        chk(32'({hreadyout, hresp}), 32'h2);
        rdc(8'h04, 32'h0);
        rdc(8'h20, 32'h0);
        rdc(8'h00, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_seq();
        xfer(1'b1, 8'h10, 32'h1F);
        xfer(1'b1, 8'h00, 32'h0);
        ins <= 1'b1;
        t0 = $time;
        wait_st(3'h1);
        chk(32'(irq), 32'h1);
        xfer(1'b1, 8'h0C, 32'h1F);
        rdc(8'h08, 32'h0);
        chk(32'(irq), 32'h0);
        xfer(1'b1, 8'h10, 32'h0);
        wait_st(3'h2);
        el = int'(($time - t0) / 5);
        chk(32'(el >= 800 && el <= 814), 32'h1);
        chk(32'(den), 32'h1);
        observe(300);
        chk(32'(nr > 0 && nr < 300 && ng == 0), 32'h1);
        wait_st(3'h3);
        t0 = $time;
        chk(32'({den, cen}), 32'h1);
        chk(32'(irq), 32'h0);
        xfer(1'b1, 8'h10, 32'h1F);
        @(posedge clk);
        chk(32'(irq), 32'h1);
        xfer(1'b1, 8'h0C, 32'h1F);
        pwm <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({den, cen}), 32'h0);
        pwm <= 1'b0;
        observe(150);
        chk(32'(ng > 0 && ng < 150 && nr == 0), 32'h1);
        wait_st(3'h4);
        el = int'(($time - t0) / 5);
        chk(32'(el >= 394 && el <= 412), 32'h1);
        observe(200);
        chk(32'(ng == 200 && nr == 0), 32'h1);
        remove();
        $display("sequence test done");
    endtask : t_seq
    task automatic t_fail(input logic mode);
        insert(mode ? 32'h4 : 32'h2);
        hot <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'({den, cen}), 32'h0);
        hot <= 1'b0;
        rdc(8'h04, 32'h23);
        cold <= 1'b1;
        repeat (mode ? 600 : 3) @(posedge clk);
        chk(32'({den, cen}), 32'h0);
        cold <= 1'b0;
        rdc(8'h04, mode ? 32'h43 : 32'hC4);
        observe(200);
        if (mode)
            chk(32'(nr > 0 && ng > 0 && nb == 0), 32'h1);
        else
            chk(32'(nr > 0 && nr < 200 && ng == 0), 32'h1);
        wait_st(3'h4);
        remove();
        $display("failure mode test done");
    endtask : t_fail
    task automatic t_mains();
        xfer(1'b1, 8'h00, 32'h8);
        ins <= 1'b1;
        repeat (1000) @(posedge clk);
        rdc(8'h04, 32'h1);
        repeat (100) begin
            mains <= 1'b1;
            repeat (2) @(posedge clk);
            mains <= 1'b0;
            repeat (2) @(posedge clk);
        end
        wait_st(3'h2);
        remove();
        $display("mains test done");
    endtask : t_mains
    task automatic t_ext();
        insert(32'h11);
        repeat (399) begin
            ext <= 1'b1;
            @(posedge clk);
            ext <= 1'b0;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        rdc(8'h04, 32'h3);
        ext <= 1'b1;
        @(posedge clk);
        ext <= 1'b0;
        wait_st(3'h4);
        remove();
        $display("external timer test done");
    endtask : t_ext
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        t_reset();
        t_seq();
        t_fail(1'b0);
        t_fail(1'b1);
        t_mains();
        t_ext();
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
